// >>> core/tlc_counter_top.v
// Purpose: tri-level up/down counter with non-volatile store and recall
// Assumes: comparator flags and enable are synchronous to mclk
// Notes:   analog pin biasing is outside; see pin assumptions below
// What this block does
// (RULE1) high-then-mid edge decrements the counter
// (RULE2) low-then-mid edge increments the counter
// (RULE3) counter saturates, never wraps
// (RULE4) counter spans 0 to 255
// (RULE5) excursions under 20us are ignored
// (RULE6) counter counts only while enable high
// (RULE7) undriven control pin idles at mid level
// (RULE8) program level starts a store write
// (RULE9) first pulse after enable or program dropped
// (RULE10) enable fall reloads from store within 10ms
// (RULE11) other side holds inputs during reload
// (RULE12) enable weakly pulled low, undriven means off
// (RULE13) other side drops enable before power off
// (RULE14) other side keeps power 100ms after write
// (RULE15) program held 200us; write done in 100ms
// (RULE16) power-up loads counter from store first
// (RULE17) store holds mid-scale before any write
// (RULE18) other side keeps pulses 200us, gaps 10us
// (RULE19) classify pin by synchronised filtered comparators
// (RULE20) counting ignored while store busy
`timescale 1ns/100ps
`include "tlc_defines.vh"
module tlc_counter_top #(
    parameter PROG_CYC = `TLC_PROG_CYC,
    parameter READ_CYC = `TLC_READ_CYC,
    parameter REJ_CYC  = `TLC_REJ_CYC
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       counterEnable,
    input  wire       ctlBelowLow,
    input  wire       ctlAboveHigh,
    input  wire       ctlAboveProg,
    output wire [7:0] counter_value,
    output wire       outputValid,
    output wire       storeBusy
);
    localparam ST_LOAD  = 3'b001;
    localparam ST_RUN   = 3'b010;
    localparam ST_WAIT  = 3'b100;

    reg  [2:0] state_ff;
    reg  [7:0] count_ff;
    reg        valid_ff;
    reg        enPrev_ff;
    reg        skip_ff;
    reg  [1:0] lvlPrev_ff;
    reg        rdReq;
    reg        wrReq;
    reg  [2:0] nxt_state;
    wire [1:0] level;
    wire [7:0] rdData;
    wire       rdDone;
    wire       nvBusy;
    wire       enRise;
    wire       enFall;
    wire       decEdge;
    wire       incEdge;
    wire       progRise;
    wire       pulseEnd;

    // saturating step, shared by both directions
    function [7:0] satStep;
        input [7:0] val;
        input       up;
        begin
            if (up)
                satStep = (val == `TLC_CNT_MAX) ? val : val + 8'h01; // RULE3 RULE4
            else
                satStep = (val == `TLC_CNT_MIN) ? val : val - 8'h01; // RULE3 RULE4
        end
    endfunction

    // comparators read low/high only when the pin leaves the biased mid point;
    // an undriven pin shows neither flag and classifies as idle
    tlc_level_filter #(
        .REJ_CYC (REJ_CYC)
    ) u_filt (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .cmpLow       (ctlBelowLow),
        .cmpHigh      (ctlAboveHigh),
        .cmpProg      (ctlAboveProg),
        .levelFilt_ff (level)
    ); // RULE7 RULE19

    tlc_nv_store #(
        .PROG_CYC (PROG_CYC),
        .READ_CYC (READ_CYC)
    ) u_nv (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .wrReq     (wrReq),
        .wrData    (count_ff),
        .rdReq     (rdReq),
        .rdData_ff (rdData),
        .rdDone_ff (rdDone),
        .busy      (nvBusy)
    );

    assign counter_value = count_ff;
    assign outputValid   = valid_ff;
    assign storeBusy     = nvBusy;

    // edge decode on filtered levels; enable low from a floating pin reads as off
    assign enRise   = counterEnable & ~enPrev_ff; // RULE12
    assign enFall   = ~counterEnable & enPrev_ff; // RULE10
    assign decEdge  = (lvlPrev_ff == `TLC_LVL_HIGH) && (level == `TLC_LVL_MID); // RULE1
    assign incEdge  = (lvlPrev_ff == `TLC_LVL_LOW) && (level == `TLC_LVL_MID);  // RULE2
    assign progRise = (lvlPrev_ff != `TLC_LVL_PROG) && (level == `TLC_LVL_PROG); // RULE8
    assign pulseEnd = decEdge | incEdge;

    // sequencing of load, run and wait-for-recall
    always @* begin
        nxt_state = state_ff;
        rdReq     = 1'b0;
        wrReq     = 1'b0;
        case (state_ff)
            ST_LOAD: begin
                rdReq = ~nvBusy; // RULE16
                if (rdDone)
                    nxt_state = ST_RUN;
                else if (!nvBusy)
                    nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (rdDone)
                    nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (enFall) begin
                    nxt_state = ST_LOAD; // RULE10
                end else if (counterEnable && progRise && !nvBusy) begin
                    wrReq = 1'b1; // RULE8 RULE6
                end
            end
            default: begin
                nxt_state = ST_LOAD;
            end
        endcase
    end

    // counter, skip flag and history; a program-level pulse ending neither counts
    // nor clears skip, so the first real pulse after a write is still dropped
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff   <= ST_LOAD;
            count_ff   <= `TLC_CNT_MID;
            valid_ff   <= 1'b0;
            enPrev_ff  <= 1'b0;
            skip_ff    <= 1'b1;
            lvlPrev_ff <= `TLC_LVL_MID;
        end else begin
            state_ff   <= nxt_state;
            enPrev_ff  <= counterEnable;
            lvlPrev_ff <= level;
            if (rdDone) begin
                count_ff <= rdData; // RULE10 RULE16
                valid_ff <= 1'b1;   // RULE16
            end else if (state_ff == ST_RUN && counterEnable && !nvBusy
                         && pulseEnd) begin // RULE6 RULE20
                if (skip_ff)
                    skip_ff <= 1'b0; // RULE9
                else
                    count_ff <= satStep(count_ff, incEdge); // RULE1 RULE2
            end
            // arm the skip after enable rises or a write starts; wins over clearing
            if (enRise || wrReq)
                skip_ff <= 1'b1; // RULE9
        end
    end
endmodule

// >>> core/tlc_defines.vh
// Purpose: shared constants for the tri-level up/down counter with store
// Assumes: 40 MHz mclk, times given in ns/us/ms
// Notes:   definitions only
`ifndef TLC_DEFINES_VH
`define TLC_DEFINES_VH

`define TLC_CLK_NS          25
`define TLC_REJ_US          20
`define TLC_REJ_CYC         ((`TLC_REJ_US * 1000) / `TLC_CLK_NS)
`define TLC_READ_MS         10
`define TLC_READ_CYC        ((`TLC_READ_MS * 1000000) / `TLC_CLK_NS)
`define TLC_PROG_MS         100
`define TLC_PROG_CYC        ((`TLC_PROG_MS * 1000000) / `TLC_CLK_NS)
`define TLC_CNT_W           8
`define TLC_CNT_MAX         8'hFF
`define TLC_CNT_MIN         8'h00
`define TLC_CNT_MID         8'h80
`define TLC_LVL_LOW         2'h0
`define TLC_LVL_MID         2'h1
`define TLC_LVL_HIGH        2'h2
`define TLC_LVL_PROG        2'h3

`endif

// >>> core/tlc_level_filter.v
// Purpose: synchronise comparator outputs and classify the pin level
// Assumes: comparator flags arrive synchronous to mclk
// Notes:   a level must persist longer than the rejection width to pass
`timescale 1ns/100ps
`include "tlc_defines.vh"
module tlc_level_filter #(
    parameter REJ_CYC = `TLC_REJ_CYC
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       cmpLow,
    input  wire       cmpHigh,
    input  wire       cmpProg,
    output reg  [1:0] levelFilt_ff
);
    reg  [2:0]  syncA_ff;
    reg  [2:0]  syncB_ff;
    reg  [1:0]  cand_ff;
    reg  [15:0] stable_ff;
    reg  [1:0]  rawLvl;

    // priority: program beats high beats low, otherwise mid
    always @* begin
        if (syncB_ff[2])
            rawLvl = `TLC_LVL_PROG;
        else if (syncB_ff[1])
            rawLvl = `TLC_LVL_HIGH;
        else if (syncB_ff[0])
            rawLvl = `TLC_LVL_LOW;
        else
            rawLvl = `TLC_LVL_MID;
    end

    // two-stage sync, then a persistence counter rejects short excursions
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_ff     <= 3'h0;
            syncB_ff     <= 3'h0;
            cand_ff      <= `TLC_LVL_MID;
            stable_ff    <= 16'h0000;
            levelFilt_ff <= `TLC_LVL_MID;
        end else begin
            syncA_ff <= {cmpProg, cmpHigh, cmpLow}; // RULE19
            syncB_ff <= syncA_ff;
            if (rawLvl != cand_ff) begin
                cand_ff   <= rawLvl;
                stable_ff <= 16'h0000;
            end else if (stable_ff < REJ_CYC[15:0]) begin
                stable_ff <= stable_ff + 16'h0001;
            end else begin
                levelFilt_ff <= cand_ff; // RULE5 RULE19
            end
        end
    end
endmodule

// >>> core/tlc_nv_store.v
// Purpose: behavioural non-volatile byte with timed write and read
// Assumes: storage survives rst_n only in the sense of a model; reset = factory value
// Notes:   busy covers the whole programming or recall time
`timescale 1ns/100ps
`include "tlc_defines.vh"
module tlc_nv_store #(
    parameter PROG_CYC = `TLC_PROG_CYC,
    parameter READ_CYC = `TLC_READ_CYC
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       wrReq,
    input  wire [7:0] wrData,
    input  wire       rdReq,
    output reg  [7:0] rdData_ff,
    output reg        rdDone_ff,
    output wire       busy
);
    reg  [7:0]  cell_ff;
    reg  [7:0]  pend_ff;
    reg  [31:0] timer_ff;
    reg         writing_ff;
    reg         reading_ff;

    assign busy = writing_ff | reading_ff;

    // one operation at a time; requests while busy are dropped
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cell_ff    <= `TLC_CNT_MID; // RULE17
            pend_ff    <= 8'h00;
            rdData_ff  <= 8'h00;
            rdDone_ff  <= 1'b0;
            timer_ff   <= 32'h00000000;
            writing_ff <= 1'b0;
            reading_ff <= 1'b0;
        end else begin
            rdDone_ff <= 1'b0;
            if (busy) begin
                if (timer_ff != 32'h00000000) begin
                    timer_ff <= timer_ff - 32'h00000001;
                end else begin
                    if (writing_ff)
                        cell_ff <= pend_ff; // RULE15
                    if (reading_ff) begin
                        rdData_ff <= cell_ff;
                        rdDone_ff <= 1'b1; // RULE10
                    end
                    writing_ff <= 1'b0;
                    reading_ff <= 1'b0;
                end
            end else if (wrReq) begin
                pend_ff    <= wrData;
                writing_ff <= 1'b1;
                timer_ff   <= PROG_CYC - 1;
            end else if (rdReq) begin
                reading_ff <= 1'b1;
                timer_ff   <= READ_CYC - 1;
            end
        end
    end
endmodule

// >>> testbench/tlc_counter_properties.sv
// Purpose: port-level properties of the tri-level counter
// Assumes: comparator flags and enable synchronous to mclk
// Notes:   a write and a queued recall are two busy stretches, one idle cycle apart
`timescale 1ns/100ps
module tlc_counter_props #(
    parameter PROG_CYC = 50,
    parameter READ_CYC = 20,
    parameter REJ_CYC  = 8
) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       counterEnable,
    input wire logic       ctlBelowLow,
    input wire logic       ctlAboveHigh,
    input wire logic       ctlAboveProg,
    input wire logic [7:0] counter_value,
    input wire logic       outputValid,
    input wire logic       storeBusy
);
    localparam int PROG_LAT = REJ_CYC + 12;
    localparam int BUSY_MAX = PROG_CYC + READ_CYC + 4;
    int  busyRun_ff;
    wire adjOk = counterEnable && !storeBusy;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // length of the current busy stretch, so a stuck store shows up
    always @(posedge mclk or negedge rst_n)
        if (!rst_n) busyRun_ff <= 0;
        else busyRun_ff <= storeBusy ? busyRun_ff + 1 : 0;
    step_one_a: assert property (
        adjOk && $past(adjOk) && $changed(counter_value)
        |-> (counter_value - $past(counter_value)) inside {8'h01, 8'hFF})
        else $error("counter moved by more than one step");
    sat_top_a: assert property (
        adjOk && $past(adjOk) && $past(counter_value) == 8'hFF |-> counter_value != 8'h00)
        else $error("counter wrapped past the top");
    sat_bot_a: assert property (
        adjOk && $past(adjOk) && $past(counter_value) == 8'h00 |-> counter_value != 8'hFF)
        else $error("counter wrapped past the bottom");
    hold_off_a: assert property (
        !counterEnable && !$past(counterEnable) && !storeBusy && !$past(storeBusy)
        && !$past(storeBusy, 2) && !$past(storeBusy, 3) |-> $stable(counter_value))
        else $error("counter changed while disabled");
    busy_freeze_a: assert property (
        storeBusy && $past(storeBusy) && counterEnable |-> $stable(counter_value))
        else $error("counter changed during store activity");
    mid_start_a: assert property (!outputValid |-> counter_value == 8'h80)
        else $error("counter not mid-scale before first load");
    recall_go_a: assert property ($fell(counterEnable) |-> ##[1:3] storeBusy)
        else $error("no recall after enable fell");
    busy_len_a: assert property (busyRun_ff <= BUSY_MAX)
        else $error("store busy too long");
    prog_go_a: assert property (
        $rose(ctlAboveProg) && adjOk && outputValid |-> ##[1:PROG_LAT] storeBusy)
        else $error("program level did not start a write");
endmodule

// >>> testbench/tlc_ctl_driver.sv
// Purpose: far-side driver of the control pin comparator flags
// Assumes: called just after a rising mclk edge
// Notes:   idle is mid level, as an undriven pin would sit
`timescale 1ns/100ps
`include "tlc_defines.vh"
module tlc_ctl_driver #(
    parameter GAP = 24
) (
    input  wire logic mclk,
    output logic      ctlBelowLow,
    output logic      ctlAboveHigh,
    output logic      ctlAboveProg
);
    // start at mid so no excursion is seen at power-up
    initial {ctlBelowLow, ctlAboveHigh, ctlAboveProg} = 3'h0;
    // one excursion, then mid for the gap before the next count
    task automatic pulse(input logic [1:0] lvl, input int hold);
        ctlBelowLow  <= (lvl == `TLC_LVL_LOW);
        ctlAboveHigh <= (lvl >= `TLC_LVL_HIGH);
        ctlAboveProg <= (lvl == `TLC_LVL_PROG);
        repeat (hold) @(posedge mclk);
        {ctlBelowLow, ctlAboveHigh, ctlAboveProg} <= 3'h0;
        repeat (GAP) @(posedge mclk);
    endtask
endmodule

// >>> testbench/tri_level_updown_counter_nvm_test.sv
// Purpose: self-checking bench of the tri-level counter with store
// Assumes: short counts PROG 120, READ 20, REJ 8 cycles
// Notes:   expected values follow from the counting and store behaviour
`timescale 1ns/100ps
`include "tlc_defines.vh"
module tri_level_updown_counter_nvm_test;
    localparam H = 24;
    logic       mclk;
    logic       rst_n;
    logic       counterEnable;
    logic       ctlBelowLow;
    logic       ctlAboveHigh;
    logic       ctlAboveProg;
    logic [7:0] counter_value;
    logic       outputValid;
    logic       storeBusy;
    int         err_count = 0;
    int         total_checks = 0;
    // write long enough that a whole counting pulse fits inside it
    tlc_counter_top #(.PROG_CYC(120), .READ_CYC(20), .REJ_CYC(8)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .counterEnable(counterEnable),
        .ctlBelowLow(ctlBelowLow), .ctlAboveHigh(ctlAboveHigh), .ctlAboveProg(ctlAboveProg),
        .counter_value(counter_value), .outputValid(outputValid), .storeBusy(storeBusy));
    tlc_ctl_driver #(.GAP(H)) u_pin (.mclk(mclk), .ctlBelowLow(ctlBelowLow),
        .ctlAboveHigh(ctlAboveHigh), .ctlAboveProg(ctlAboveProg));
    task automatic chk(input logic [7:0] exp);
        total_checks++;
        if (counter_value !== exp) begin
            err_count++;
            $display("Error at %0t: counter %h expected %h", $time, counter_value, exp);
        end
    endtask
    // wait out a recall or write; inputs stay put meanwhile
    task automatic settle;
        int n;
        repeat (4) @(posedge mclk);
        for (n = 0; n < 300 && storeBusy !== 1'b0; n++) @(posedge mclk);
        if (storeBusy !== 1'b0) begin
            err_count++;
            $display("Error at %0t: store stayed busy", $time);
        end
        repeat (4) @(posedge mclk);
    endtask
    task automatic enable(input logic v);
        counterEnable <= v;
        if (v) repeat (10) @(posedge mclk);
        else settle;
    endtask
    task automatic t_reset;
        settle;
        chk(8'h80);
        total_checks++;
        if (outputValid !== 1'b1) begin
            err_count++;
            $display("Error at %0t: output not valid after load", $time);
        end
    endtask
    task automatic t_counting;
        enable(1'b1);
        u_pin.pulse(`TLC_LVL_LOW, H);
        chk(8'h80);
        u_pin.pulse(`TLC_LVL_LOW, H);
        chk(8'h81);
        u_pin.pulse(`TLC_LVL_HIGH, H);
        chk(8'h80);
        u_pin.pulse(`TLC_LVL_LOW, 4);
        u_pin.pulse(`TLC_LVL_HIGH, 4);
        chk(8'h80);
    endtask
    task automatic t_disabled;
        enable(1'b0);
        u_pin.pulse(`TLC_LVL_LOW, H);
        chk(8'h80);
        enable(1'b1);
        u_pin.pulse(`TLC_LVL_HIGH, H);
        chk(8'h80);
    endtask
    task automatic t_saturate;
        repeat (128) u_pin.pulse(`TLC_LVL_LOW, H);
        chk(8'hFF);
        repeat (256) u_pin.pulse(`TLC_LVL_HIGH, H);
        chk(8'h00);
    endtask
    task automatic t_program;
        repeat (3) u_pin.pulse(`TLC_LVL_LOW, H);
        chk(8'h03);
        u_pin.pulse(`TLC_LVL_PROG, H);
        // this pulse ends while the write runs: neither counted nor using up the skip
        u_pin.pulse(`TLC_LVL_LOW, H);
        chk(8'h03);
        settle;
        u_pin.pulse(`TLC_LVL_LOW, H);
        chk(8'h03);
        u_pin.pulse(`TLC_LVL_LOW, H);
        chk(8'h04);
        enable(1'b0);
        chk(8'h03);
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // free-running 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // reset for two cycles, then the scenarios in order
    initial begin
        rst_n = 1'b0;
        counterEnable = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_counting;
        t_disabled;
        t_saturate;
        t_program;
        finish_test;
    end
    // the scenarios need about 19200 cycles; over twice that means a hang
    initial begin
        repeat (42000) @(posedge mclk);
        err_count++;
        $display("Error at %0t: timeout", $time);
        finish_test;
    end
endmodule
bind tlc_counter_top tlc_counter_props #(
    .PROG_CYC(PROG_CYC), .READ_CYC(READ_CYC), .REJ_CYC(REJ_CYC)) u_props (
    .mclk(mclk), .rst_n(rst_n), .counterEnable(counterEnable),
    .ctlBelowLow(ctlBelowLow), .ctlAboveHigh(ctlAboveHigh), .ctlAboveProg(ctlAboveProg),
    .counter_value(counter_value), .outputValid(outputValid), .storeBusy(storeBusy));
